// ===== verilog/cbd_curve_buffer.sv
// Purpose: curve buffer select, capture and single curve dump
// Assumes: sample vector comes from logic on clk_i; trigger is a pin
// Notes:   host paces dump by polling the ready and done status bits
`timescale 1ns/1ps
module cbd_curve_buffer
  import cbd_pkg::*;
(
  input  wire logic                  clk_i,          // 50 MHz clock
  input  wire logic                  rst_i,          // sync reset, high
  input  wire logic                  wb_cyc_i,       // wishbone cycle
  input  wire logic                  wb_stb_i,       // wishbone strobe
  input  wire logic                  wb_we_i,        // wishbone write
  input  wire logic [7:0]            wb_adr_i,       // byte address
  input  wire logic [3:0]            wb_sel_i,       // byte enables
  input  wire logic [31:0]           wb_dat_i,       // write data
  output logic      [31:0]           wb_dat_o,       // read data
  output logic                       wb_ack_o,       // acknowledge
  input  wire logic                  sample_i,       // one point strobe
  input  wire logic [NCURVE_DUAL*PT_W-1:0] sample_data_i, // all outputs
  input  wire logic [4:0]            sens_setting_i, // channel 1 sensitivity
  input  wire logic [1:0]            input_mode_setting_i, // input mode
  input  wire logic [4:0]            sens2_setting_i, // channel 2 sensitivity
  input  wire logic                  trigger_i,      // external trigger pin
  output logic      [12:0]           burst_period_o, // burst us per point
  output logic      [3:0]            aux_mode_o      // aux capture mode
);
  // ************************************************************
  // types and state
  // ************************************************************
  typedef enum logic [1:0] {A_IDLE = 2'b00, A_ARMED = 2'b01, A_RUN = 2'b10, A_STORE = 2'b11} cbd_acq_e;
  typedef enum logic [1:0] {D_IDLE = 2'b00, D_FETCH = 2'b01, D_WAIT = 2'b10, D_READY = 2'b11} cbd_dmp_e;

  logic [PT_W-1:0]        mem [STORE_DEPTH];
  cbd_acq_e               acq_q;
  cbd_dmp_e               dmp_q;
  logic [20:0]            mask_q;
  logic [15:0]            len_q;
  logic                   dual_q;
  logic                   float_q;
  logic [3:0]             aux_q;
  logic [12:0]            burst_q;
  logic                   cont_q;
  logic [15:0]            pt_q;
  logic [4:0]             bit_q;
  logic [4:0]             slot_q;
  logic [NCURVE_DUAL*PT_W-1:0] smp_q;
  logic [15:0]            dpt_q;
  logic [4:0]             dslot_q;
  logic [PT_W-1:0]        rd_q;
  logic [PT_W-1:0]        dval_q;
  logic                   ready_q;
  logic                   done_q;
  logic                   err_q;
  logic                   warn_q;
  logic                   ack_q;
  logic [1:0]             trg_sync_q;
  logic                   trg_prev_q;

  // ************************************************************
  // combinational helpers
  // ************************************************************
  logic [20:0] eff_mask;
  logic [4:0]  ncurves;
  logic [15:0] max_len;
  logic [15:0] dual_max;
  logic        wr_stb;
  logic        rd_stb;
  logic [20:0] new_mask;
  logic [4:0]  new_cnt;
  logic [15:0] new_max;
  logic [15:0] new_len;
  logic [4:0]  dump_bit;
  logic        dump_ok;
  logic [4:0]  dump_slot;
  logic        aux_two;
  logic        burst_ok;
  logic [12:0] burst_min;
  logic        trg_rise;
  logic [PT_W-1:0] cur_val;

  function automatic logic [15:0] fit_len(input logic [4:0] n);
    // an empty view (dual off, upper bits only) must not force the length to zero
    fit_len = (n == 5'h00) ? 16'(STORE_DEPTH) : 16'(STORE_DEPTH / int'(n));
  endfunction

  function automatic logic [4:0] ones_below(input logic [20:0] m, input logic [4:0] b);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < NCURVE_DUAL; i++)
      if (i < int'(b) && m[i]) c = c + 5'h01;
    ones_below = c;
  endfunction

  // bus strobes and mask views
  assign wr_stb   = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && (wb_sel_i != 4'h0);
  assign rd_stb   = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
  assign eff_mask = dual_q ? (mask_q & MASK_DUAL) : (mask_q & MASK_SINGLE);
  assign ncurves  = 5'($countones(eff_mask));
  assign max_len  = fit_len(ncurves);
  assign dual_max = fit_len(5'($countones(mask_q & MASK_DUAL)));
  assign new_mask = wb_dat_i[20:0];
  assign new_cnt  = 5'($countones(new_mask));
  assign new_max  = fit_len(new_cnt);
  assign new_len  = (wb_dat_i[15:0] == 16'h0000) ? 16'h0001 : wb_dat_i[15:0];
  assign dump_bit = wb_dat_i[4:0];
  // bit must be in range for the mode and selected in the live mask
  assign dump_ok  = (wb_dat_i[31:5] == 27'h0) && (dump_bit < (dual_q ? 5'd21 : 5'd16))
                    && eff_mask[dump_bit];
  assign dump_slot = ones_below(eff_mask, dump_bit);
  assign aux_two   = (aux_q >= AUXMODE_FIRST) && (aux_q <= AUXMODE_LAST) && aux_q[0];
  assign burst_min = aux_two ? BURST_MIN_TWO : BURST_MIN_ONE;
  assign burst_ok  = (wb_dat_i[12:0] >= burst_min) && (wb_dat_i[12:0] <= BURST_MAX)
                     && (wb_dat_i[31:13] == 19'h0);
  assign trg_rise  = trg_sync_q[1] && !trg_prev_q;

  // value stored for the curve now walked; sensitivity carries input mode
  always_comb
  begin
    cur_val = smp_q[int'(bit_q)*PT_W +: PT_W];
    if (int'(bit_q) == BIT_SENS1)
      cur_val = {9'h000, 7'({2'b00, sens_setting_i}) + 7'(input_mode_setting_i) * INPUT_MODE_SETTING_STEP};
    else if (int'(bit_q) == BIT_SENS2)
      cur_val = {9'h000, 7'({2'b00, sens2_setting_i}) + 7'(input_mode_setting_i) * INPUT_MODE_SETTING_STEP};
  end

  // ************************************************************
  // wishbone slave
  // ************************************************************
  // ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i) ack_q <= 1'b0;
    else       ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
  end
  assign wb_ack_o = ack_q;

  // read mux registered; unmapped offsets read as zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i) wb_dat_o <= 32'h0;
    else if (rd_stb)
    begin
      case (wb_adr_i)
        REG_SELECT: wb_dat_o <= {11'h0, eff_mask};
        REG_LENGTH: wb_dat_o <= {16'h0, len_q};
        REG_MODE:   wb_dat_o <= {26'h0, float_q, aux_q, dual_q};
        REG_DATA:   wb_dat_o <= {16'h0, dval_q};
        REG_STATUS: wb_dat_o <= {24'h0, ready_q, 2'b00, warn_q, err_q, (acq_q != A_IDLE), done_q, 1'b0};
        REG_BURST:  wb_dat_o <= {19'h0, burst_q};
        REG_COUNT:  wb_dat_o <= {27'h0, ncurves};
        default:    wb_dat_o <= 32'h0;
      endcase
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  // selection mask, length, mode and burst period
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_q  <= RST_MASK;
      len_q   <= RST_LEN;
      dual_q  <= 1'b0;
      float_q <= 1'b0;
      aux_q   <= 4'h0;
      burst_q <= RST_BURST;
    end
    else if (wr_stb)
    begin
      case (wb_adr_i)
        REG_SELECT:
        begin
          // out-of-range masks leave the old selection in force
          if (new_mask != 21'h0 && (dual_q || new_mask[20:16] == 5'h00))
          begin
            mask_q <= new_mask;
            if (len_q > new_max) len_q <= new_max;
          end
        end
        REG_LENGTH: len_q <= (new_len > max_len) ? max_len : new_len;
        REG_MODE:
        begin
          dual_q  <= wb_dat_i[0];
          aux_q   <= wb_dat_i[4:1];
          float_q <= wb_dat_i[5];
          // turning dual on brings stored upper bits back into view
          if (wb_dat_i[0] && len_q > dual_max) len_q <= dual_max;
        end
        REG_BURST: if (burst_ok) burst_q <= wb_dat_i[12:0];
        default: ;
      endcase
    end
  end
  assign burst_period_o = burst_q;
  assign aux_mode_o     = aux_q;

  // command error: rejected mask, burst or dump; cleared by status read
  always_ff @(posedge clk_i)
  begin
    if (rst_i) err_q <= 1'b0;
    else if (wr_stb && wb_adr_i == REG_DUMP && !dump_ok) err_q <= 1'b1;
    else if (wr_stb && wb_adr_i == REG_SELECT && (new_mask == 21'h0 || (!dual_q && new_mask[20:16] != 5'h00)))
      err_q <= 1'b1;
    else if (wr_stb && wb_adr_i == REG_BURST && !burst_ok) err_q <= 1'b1;
    else if (rd_stb && wb_adr_i == REG_STATUS) err_q <= 1'b0;
  end

  // warn when a float dump of a scaled output lacks the sensitivity curve
  always_ff @(posedge clk_i)
  begin
    if (rst_i) warn_q <= 1'b0;
    else if (wr_stb && wb_adr_i == REG_DUMP && dump_ok)
      warn_q <= float_q && (|(MASK_NEED_SENS & (21'h1 << dump_bit))) && !eff_mask[BIT_SENS1];
  end

  // ************************************************************
  // acquisition
  // ************************************************************
  // trigger pin synchroniser, second stage feeds the edge detector
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trg_sync_q <= 2'b00;
      trg_prev_q <= 1'b0;
    end
    else
    begin
      trg_sync_q <= {trg_sync_q[0], trigger_i};
      trg_prev_q <= trg_sync_q[1];
    end
  end

  // each sample point walks the 21 bits, one store write per cycle,
  // so samples must come at least 22 cycles apart
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acq_q  <= A_IDLE;
      cont_q <= 1'b0;
      pt_q   <= 16'h0;
      bit_q  <= 5'h0;
      slot_q <= 5'h0;
      smp_q  <= '0;
    end
    else
    begin
      if (wr_stb && wb_adr_i == REG_TAKE && wb_dat_i[3])
        acq_q <= A_IDLE;
      else
      begin
        case (acq_q)
          A_IDLE:
          begin
            if (wr_stb && wb_adr_i == REG_TAKE && wb_dat_i[2:0] != 3'b000)
            begin
              pt_q   <= 16'h0;
              cont_q <= wb_dat_i[2];
              acq_q  <= wb_dat_i[1] ? A_ARMED : A_RUN;
            end
          end
          A_ARMED: if (trg_rise) acq_q <= A_RUN;
          A_RUN:
          begin
            if (sample_i)
            begin
              smp_q  <= sample_data_i;
              bit_q  <= 5'h0;
              slot_q <= 5'h0;
              acq_q  <= A_STORE;
            end
          end
          A_STORE:
          begin
            if (eff_mask[bit_q]) slot_q <= slot_q + 5'h01;
            if (bit_q == 5'd20)
            begin
              if (pt_q + 16'h1 >= len_q)
              begin
                pt_q  <= 16'h0;
                acq_q <= cont_q ? A_RUN : A_IDLE;
              end
              else
              begin
                pt_q  <= pt_q + 16'h1;
                acq_q <= A_RUN;
              end
            end
            bit_q <= bit_q + 5'h01;
          end
          default: acq_q <= A_IDLE;
        endcase
      end
    end
  end

  // store write: only selected outputs take a slot
  always_ff @(posedge clk_i)
  begin
    if (acq_q == A_STORE && eff_mask[bit_q])
      mem[STORE_AW'(32'(slot_q) * 32'(len_q) + 32'(pt_q))] <= cur_val;
  end

  // ************************************************************
  // single curve dump
  // ************************************************************
  // synchronous read port for the dump
  always_ff @(posedge clk_i)
  begin
    rd_q <= mem[STORE_AW'(32'(dslot_q) * 32'(len_q) + 32'(dpt_q))];
  end

  // one curve per request, value handed out one read at a time
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dmp_q   <= D_IDLE;
      dpt_q   <= 16'h0;
      dslot_q <= 5'h0;
      dval_q  <= '0;
      ready_q <= 1'b0;
      done_q  <= 1'b0;
    end
    else
    begin
      case (dmp_q)
        D_IDLE:
        begin
          if (wr_stb && wb_adr_i == REG_DUMP && dump_ok)
          begin
            dslot_q <= dump_slot;
            dpt_q   <= 16'h0;
            done_q  <= 1'b0;
            dmp_q   <= D_FETCH;
          end
        end
        D_FETCH: dmp_q <= D_WAIT;
        D_WAIT:
        begin
          dval_q  <= rd_q;
          ready_q <= 1'b1;
          dmp_q   <= D_READY;
        end
        D_READY:
        begin
          if (rd_stb && wb_adr_i == REG_DATA)
          begin
            ready_q <= 1'b0;
            if (dpt_q + 16'h1 >= len_q)
            begin
              done_q <= 1'b1;
              dmp_q  <= D_IDLE;
            end
            else
            begin
              dpt_q <= dpt_q + 16'h1;
              dmp_q <= D_FETCH;
            end
          end
        end
        default: dmp_q <= D_IDLE;
      endcase
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  len_fits_a: assert property (@(posedge clk_i) disable iff (rst_i) len_q <= max_len)
    else $error("curve length exceeds share of store");
  shrink_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_stb && wb_adr_i == REG_SELECT && new_mask != 21'h0 && (dual_q || new_mask[20:16] == 5'h00)
     && len_q > new_max) |=> len_q == $past(new_max))
    else $error("length not reduced on new selection");
  single_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_stb && wb_adr_i == REG_SELECT && !dual_q && new_mask[20:16] != 5'h00) |=> $stable(mask_q))
    else $error("wide mask taken in single mode");
  zero_mask_a: assert property (@(posedge clk_i) disable iff (rst_i) eff_mask != 21'h0 || !dual_q && mask_q[15:0] == 16'h0)
    else $error("empty selection in force");
  bad_dump_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_stb && wb_adr_i == REG_DUMP && !dump_ok && dmp_q == D_IDLE) |=> dmp_q == D_IDLE && err_q)
    else $error("rejected dump started a transfer");
  ready_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (dmp_q == D_FETCH) |=> ##1 ready_q)
    else $error("value ready not raised two cycles after fetch");
  done_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(done_q) |-> $past(dpt_q) + 16'h1 >= len_q && !ready_q)
    else $error("transfer ended early");
  burst_rng_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(burst_q) |-> burst_q >= $past(burst_min) && burst_q <= BURST_MAX)
    else $error("burst period outside limits");
  store_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (acq_q == A_STORE) |=> slot_q == $past(slot_q) + 5'($past(eff_mask[bit_q])) || $past(bit_q) == 5'd20)
    else $error("slot advanced for unselected output");
  sens_val_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (acq_q == A_STORE && int'(bit_q) == BIT_SENS1) |-> cur_val[6:5] == input_mode_setting_i
     || sens_setting_i[4:0] + 7'h0 > 7'h1F)
    else $error("sensitivity point lacks input mode offset");
  dump_cv:   cover property (@(posedge clk_i) disable iff (rst_i) $rose(done_q));
  shrink_cv: cover property (@(posedge clk_i) disable iff (rst_i) $fell(len_q == RST_LEN));
  trig_cv:   cover property (@(posedge clk_i) disable iff (rst_i) acq_q == A_ARMED ##1 acq_q == A_RUN);
endmodule

// ===== pkg/cbd_pkg.sv
// Purpose: constants for the curve buffer capture and dump block
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   one shared point store split among the selected curves
// ************************************************************
// package
// ************************************************************
package cbd_pkg;
  // store and mask geometry
  localparam int          STORE_DEPTH   = 32768;
  localparam int          STORE_AW      = 15;
  localparam int          PT_W          = 16;
  localparam int          NCURVE_DUAL   = 21;
  localparam int          NCURVE_SINGLE = 16;
  localparam logic [20:0] MASK_SINGLE   = 21'h00FFFF;
  localparam logic [20:0] MASK_DUAL     = 21'h1FFFFF;
  // curve bit positions with special meaning
  localparam int          BIT_SENS1     = 4;
  localparam int          BIT_SENS2     = 20;
  localparam logic [20:0] MASK_NEED_SENS = 21'h000407; // x, y, magnitude, noise
  localparam logic [6:0]  INPUT_MODE_SETTING_STEP    = 7'h20;       // offset per input mode
  // register byte offsets
  localparam logic [7:0]  REG_SELECT    = 8'h00;
  localparam logic [7:0]  REG_LENGTH    = 8'h04;
  localparam logic [7:0]  REG_MODE      = 8'h08;
  localparam logic [7:0]  REG_TAKE      = 8'h0C;
  localparam logic [7:0]  REG_DUMP      = 8'h10;
  localparam logic [7:0]  REG_DATA      = 8'h14;
  localparam logic [7:0]  REG_STATUS    = 8'h18;
  localparam logic [7:0]  REG_BURST     = 8'h1C;
  localparam logic [7:0]  REG_COUNT     = 8'h20;
  // status bit positions
  localparam int          ST_READY      = 7;
  localparam int          ST_DONE       = 1;
  localparam int          ST_ACQ        = 2;
  localparam int          ST_ERR        = 3;
  localparam int          ST_SENSWARN   = 4;
  // reset values
  localparam logic [20:0] RST_MASK      = 21'h000001;
  localparam logic [15:0] RST_LEN       = 16'h8000;
  localparam logic [12:0] RST_BURST     = 13'h0019;
  // burst time per point limits, microseconds
  localparam logic [12:0] BURST_MIN_ONE = 13'h0019;    // 25
  localparam logic [12:0] BURST_MIN_TWO = 13'h0038;    // 56
  localparam logic [12:0] BURST_MAX     = 13'h1388;    // 5000
  localparam logic [3:0]  AUXMODE_FIRST = 4'h2;
  localparam logic [3:0]  AUXMODE_LAST  = 4'hD;
endpackage

// ===== verif/cbd_host_model.sv
// Purpose: host side model issuing classic wishbone commands to the block
// Assumes: one request at a time, answer awaited without a fixed latency
// Notes:   released lines show inverted values so stale data is never trusted
`timescale 1ns/1ps
// ************************************************************
// host model
// ************************************************************
module cbd_host_model
  import cbd_pkg::*;
(
  input  wire logic        clk_i,    // bus clock
  output logic             wb_cyc_o, // cycle
  output logic             wb_stb_o, // strobe
  output logic             wb_we_o,  // write enable
  output logic [7:0]       wb_adr_o, // byte address
  output logic [3:0]       wb_sel_o, // byte enables
  output logic [31:0]      wb_dat_o, // write data
  input  wire logic        wb_ack_i, // acknowledge
  input  wire logic [31:0] wb_dat_i  // read data
);
  logic [31:0] dump_q [0:15]; // values taken by the last dump
  logic        done_seen;     // end of transfer seen after last dump

  // idle bus at time zero
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end

  // one cycle; everything held until ack is sampled, then released
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= a;
    wb_sel_o <= 4'hF;
    wb_dat_o <= d;
    @(posedge clk_i);
    while (wb_ack_i !== 1'b1)
      @(posedge clk_i);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= 1'b0;
    wb_adr_o <= ~a;
    wb_dat_o <= ~d;
  endtask

  // dumps in the mode already set; the bench also uses it for a float dump
  task automatic dump_curve(input logic [31:0] n, input int len);
    logic [31:0] s;
    wb_cycle(1'b1, REG_DUMP, n, s);
    for (int k = 0; k < len; k++)
    begin
      s = 32'h0;
      while (s[ST_READY] !== 1'b1)
        wb_cycle(1'b0, REG_STATUS, 32'h0, s);
      wb_cycle(1'b0, REG_DATA, 32'h0, dump_q[k]);
    end
    wb_cycle(1'b0, REG_STATUS, 32'h0, s);
    done_seen = s[ST_DONE];
  endtask
endmodule

// ===== verif/tb.sv
// Purpose: self-checking bench for the curve buffer block
// Assumes: host model speaks the bus, bench drives the sample source
// Notes:   short curves keep the run brief; store sharing checked by reads
`timescale 1ns/1ps
module tb
  import cbd_pkg::*;
;
  localparam int LEN = 4;
  logic                          clk_i;
  logic                          rst_i;
  wire                           wb_cyc, wb_stb, wb_we, wb_ack;
  wire  [7:0]                    wb_adr;
  wire  [3:0]                    wb_sel;
  wire  [31:0]                   wb_wdat, wb_rdat;
  logic                          sample_i;
  logic [NCURVE_DUAL*PT_W-1:0]   sample_data;
  logic                          trigger_i;
  wire  [12:0]                   burst_period;
  wire  [3:0]                    aux_mode;
  int                            miscompares = 0;
  int                            n_tests = 0;
  int                            cycles = 0;
  logic [31:0]                   scratch;
  // burst table: aux mode, period written, period expected
  logic [3:0]  b_aux [6] = '{4'h3, 4'h3, 4'h3, 4'h2, 4'h2, 4'h2};
  logic [12:0] b_val [6] = '{13'h0037, 13'h0038, 13'h1389, 13'h0018, 13'h0019, 13'h1388};
  logic [12:0] b_exp [6] = '{13'h0019, 13'h0038, 13'h0038, 13'h0038, 13'h0019, 13'h1388};

  cbd_host_model i_cbd_host_model (.clk_i(clk_i), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
    .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat), .wb_ack_i(wb_ack), .wb_dat_i(wb_rdat));
  cbd_curve_buffer i_cbd_curve_buffer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .sample_i(sample_i), .sample_data_i(sample_data), .sens_setting_i(5'h05),
    .input_mode_setting_i(2'h2), .sens2_setting_i(5'h07), .trigger_i(trigger_i),
    .burst_period_o(burst_period), .aux_mode_o(aux_mode));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic test_done();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_cbd_host_model.wb_cycle(1'b1, a, d, scratch);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    i_cbd_host_model.wb_cycle(1'b0, a, 32'h0, v);
    chk(what, e, v);
  endtask

  // one sample point, output n carries v0 plus n in the upper byte; points kept well apart
  task automatic send_point(input logic [15:0] v0);
    @(posedge clk_i);
    for (int n = 0; n < NCURVE_DUAL; n++)
      sample_data[n*PT_W +: PT_W] <= v0 + 16'(n << 8);
    sample_i <= 1'b1;
    @(posedge clk_i);
    sample_i <= 1'b0;
    repeat (24) @(posedge clk_i);
  endtask

  task automatic capture(input logic [31:0] mode, input logic [15:0] base);
    wr(REG_TAKE, mode);
    if (mode == 32'h2)
    begin
      @(posedge clk_i);
      trigger_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      trigger_i <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    for (int p = 0; p < LEN; p++)
      send_point(base + 16'(p));
  endtask

  // sensitivity point is 5 plus input mode 2 times 32
  task automatic check_dump(input int b, input logic [15:0] base);
    logic [15:0] e;
    i_cbd_host_model.dump_curve(32'(b), LEN);
    for (int k = 0; k < LEN; k++)
    begin
      e = (b == BIT_SENS1) ? 16'h0045 : 16'(b << 8) + base + 16'(k);
      chk("dump value", {16'h0, e}, i_cbd_host_model.dump_q[k]);
    end
    chk("dump done", 32'h1, {31'h0, i_cbd_host_model.done_seen});
  endtask

  task automatic dump_refused(input logic [31:0] b);
    logic [31:0] s;
    wr(REG_DUMP, b);
    i_cbd_host_model.wb_cycle(1'b0, REG_STATUS, 32'h0, s);
    chk("refused dump", 32'h08, s & 32'h88);
  endtask

  // ************************************************************
  // clock, timeout and sequence
  // ************************************************************
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // a hang is counted and ends the run
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      test_done();
    end
  end

  initial
  begin
    rst_i = 1'b1;
    sample_i = 1'b0;
    sample_data = '0;
    trigger_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("select reset", REG_SELECT, 32'h1);
    rd("length reset", REG_LENGTH, 32'h8000);
    rd("burst reset", REG_BURST, 32'h19);
    rd("count reset", REG_COUNT, 32'h1);
    wr(8'h24, 32'h5);
    rd("unmapped", 8'h24, 32'h0);
    wr(REG_SELECT, 32'h0);
    rd("mask zero", REG_SELECT, 32'h1);
    wr(REG_SELECT, 32'h10000);
    rd("mask single", REG_SELECT, 32'h1);
    wr(REG_MODE, 32'h1);
    wr(REG_SELECT, 32'h1FFFFF);
    rd("count dual", REG_COUNT, 32'h15);
    rd("length dual", REG_LENGTH, 32'h618);
    wr(REG_MODE, 32'h0);
    wr(REG_SELECT, 32'h15);
    wr(REG_LENGTH, 32'h8000);
    rd("length clamp", REG_LENGTH, 32'h2AAA);
    wr(REG_SELECT, 32'h1F);
    rd("length shrink", REG_LENGTH, 32'h1999);
    wr(REG_SELECT, 32'h15);
    wr(REG_LENGTH, 32'(LEN));
    capture(32'h1, 16'h0000);
    check_dump(0, 16'h0000);
    check_dump(2, 16'h0000);
    check_dump(4, 16'h0000);
    dump_refused(32'h1);
    dump_refused(32'h10);
    wr(REG_SELECT, 32'hC000);
    rd("length kept", REG_LENGTH, 32'(LEN));
    capture(32'h2, 16'h0010);
    check_dump(15, 16'h0010);
    scratch = i_cbd_host_model.dump_q[0];
    check_dump(14, 16'h0010);
    chk("frequency", 32'h0F100E10, scratch * 32'h10000 + i_cbd_host_model.dump_q[0]);
    dump_refused(32'h0);
    wr(REG_SELECT, 32'h1);
    wr(REG_MODE, 32'h20);
    i_cbd_host_model.dump_curve(32'h0, LEN);
    rd("float warn", REG_STATUS, 32'h12);
    wr(REG_TAKE, 32'h4);
    rd("acquiring", REG_STATUS, 32'h16);
    wr(REG_TAKE, 32'h8);
    rd("halted", REG_STATUS, 32'h12);
    for (int i = 0; i < 6; i++)
    begin
      wr(REG_MODE, {27'h0, b_aux[i], 1'b0});
      wr(REG_BURST, {19'h0, b_val[i]});
      rd("burst read", REG_BURST, {19'h0, b_exp[i]});
      chk("burst port", {19'h0, b_exp[i]}, {19'h0, burst_period});
      chk("aux port", {28'h0, b_aux[i]}, {28'h0, aux_mode});
    end
    test_done();
  end
endmodule
